// ===== src/alarm_afe_control_regs.v
// Control register bank of the alarm front end with sleep timer and pin routing
`timescale 1ns/10ps
`include "alarm_afe_consts.vh"

// Functional notes
// - LED select bit routes enable to A/B
// - Precharge runs boost while power good is low
// - Direction bit picks interconnect forwarding way
// - LED pin gate lets pin enable LEDs
// - Horn gate lets sounder pin enable horn
// - Sleep enable starts timer; expiry sets done
// - Regulator off bit turns host regulator off
// - Brownout off bit disables supply monitor
// - Regulator error faults unless disabled
// - Overtemp control enables fault and flag
// - Soft reset restores defaults except precharge, self clears
// - Low supply boost runs boost on low
// - Duration: high byte then low byte
// - Duration N gives N milliseconds
// - Rewrite while sleeping applies next time
// - Writing zero stops timer at once
// - Zero duration holds; nonzero write starts
// - Mux select: off, gas, photo, photodiode
// - Bypass swaps mux buffer for switch
// - Pin code 2 drives error summary
// - Pin codes 4,5,7 OR into enables
module alarm_afe_control_regs #(
  parameter TICK_CYCLES = `SLEEP_TICK_CYCLES,
  parameter DUR_W       = 16
) (
  input  wire       i_core_clk,          // Core clock, 125 MHz
  input  wire       i_rst,               // Synchronous reset, active high
  input  wire [7:0] i_reg_addr,          // Register offset
  input  wire [7:0] i_reg_wdata,         // Write data
  input  wire       i_reg_wr,            // Write strobe, one cycle
  input  wire       i_reg_rd,            // Read strobe, one cycle
  output reg  [7:0] o_reg_rdata,         // Read data, valid cycle after strobe
  input  wire       i_boost_enable,      // Boost enable bit of the other bank
  input  wire       i_load_test_enable,  // Load test enable bit of the other bank
  input  wire       i_status_error_any,  // Any unmasked status error flag
  input  wire       i_overtemp_flag_clr, // Clear of the overtemp error flag
  input  wire       i_fault_clr,         // Clear of fault mode
  input  wire       i_led_a_enable_input,// LED A enable pin
  input  wire       i_led_b_enable_input,// LED B enable pin
  input  wire       i_led_enable_pin,    // LED block enable pin
  input  wire       i_sounder_enable_pin,// Horn block enable pin
  input  wire       i_boost_power_good,  // Boost power good comparator
  input  wire       i_supply_low,        // Supply brown-out comparator
  input  wire       i_regulator_error,   // Host regulator error detector
  input  wire       i_overtemp,          // Over-temperature detector
  input  wire       i_int_unit,          // Unit-side interconnect pin level
  output reg        o_int_unit,          // Unit-side interconnect drive value
  output reg        o_int_unit_oe_n,     // Unit-side drive enable, low drives
  input  wire       i_int_mcu,           // MCU-side interconnect pin level
  output reg        o_int_mcu,           // MCU-side interconnect drive value
  output reg        o_int_mcu_oe_n,      // MCU-side drive enable, low drives
  input  wire       i_mp_pin,            // Multi-purpose pin level
  output reg        o_mp_pin,            // Multi-purpose pin drive value
  output reg        o_mp_pin_oe_n,       // Multi-purpose pin enable, low drives
  output reg        o_led_a_on,          // LED channel A enable
  output reg        o_led_b_on,          // LED channel B enable
  output reg        o_horn_on,           // Horn block enable
  output reg        o_boost_run,         // Boost converter run
  output reg        o_host_regulator_on, // Host regulator enable
  output reg        o_brownout_mon_on,   // Brown-out monitor enable
  output reg        o_supply_low_flag,   // Qualified supply low flag
  output reg        o_fault_mode,        // Fault mode, sticky
  output reg        o_overtemp_error_flag,// Overtemp error flag, sticky
  output reg        o_load_test_on,      // Load test enable
  output reg  [1:0] o_mux_select,        // Analog mux source
  output reg        o_mux_buffer_on,     // Analog mux buffer enable
  output reg        o_mux_bypass_on,     // Low-resistance bypass switch
  output reg        o_sleep_active,      // Sleep timer counting
  output reg        o_sleep_done,        // Sleep done event, one cycle
  output reg        o_soft_reset,        // Soft reset event to other banks
  output reg  [7:0] o_gas_amp_and_load_test // Gas amp and load test settings
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam NSYNC = 11;

  wire [NSYNC-1:0] async_in;
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;

  assign async_in = {i_led_a_enable_input, i_led_b_enable_input, i_led_enable_pin,
                     i_sounder_enable_pin, i_boost_power_good, i_supply_low,
                     i_regulator_error, i_overtemp, i_int_unit, i_int_mcu, i_mp_pin};

  // Two flip-flops per pin; only the second one feeds logic
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= async_in[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  // Synchronised pin levels
  wire s_led_a   = sync_b[10];
  wire s_led_b   = sync_b[9];
  wire s_led_pin = sync_b[8];
  wire s_sounder = sync_b[7];
  wire s_pg      = sync_b[6];
  wire s_low     = sync_b[5];
  wire s_regerr  = sync_b[4];
  wire s_ot      = sync_b[3];
  wire s_unit    = sync_b[2];
  wire s_mcu     = sync_b[1];
  wire s_mp      = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  reg [7:0] enable_group_two;
  reg [7:0] supervisor_control;
  reg [7:0] sleep_duration_high;
  reg [7:0] sleep_duration_low;
  reg [7:0] pin_and_mux_config;
  reg [7:0] gas_amp_and_load_test;

  // Write decode per offset
  wire wr_en2  = i_reg_wr && (i_reg_addr == `OFS_ENABLE_GROUP_TWO);
  wire wr_ctl  = i_reg_wr && (i_reg_addr == `OFS_SUPERVISOR_CONTROL);
  wire wr_hi   = i_reg_wr && (i_reg_addr == `OFS_SLEEP_DURATION_HIGH);
  wire wr_lo   = i_reg_wr && (i_reg_addr == `OFS_SLEEP_DURATION_LOW);
  wire wr_pin  = i_reg_wr && (i_reg_addr == `OFS_PIN_AND_MUX_CONFIG);
  wire wr_gas  = i_reg_wr && (i_reg_addr == `OFS_GAS_AMP_AND_LOAD_TEST);
  wire soft_rst = wr_ctl && i_reg_wdata[`BIT_SOFT_RESET];

  // Sleep enable and the assembled duration
  wire sleep_en = enable_group_two[`BIT_SLEEP_ENABLE];
  wire [DUR_W-1:0] duration = {sleep_duration_high, sleep_duration_low};
  wire sleep_expire;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      enable_group_two      <= `RST_ENABLE_GROUP_TWO;
      supervisor_control    <= `RST_SUPERVISOR_CONTROL;
      sleep_duration_high   <= `RST_SLEEP_DURATION_HIGH;
      sleep_duration_low    <= `RST_SLEEP_DURATION_LOW;
      pin_and_mux_config    <= `RST_PIN_AND_MUX_CONFIG;
      gas_amp_and_load_test <= `RST_GAS_AMP_AND_LOAD_TEST;
    end else if (soft_rst) begin
      // Precharge bit survives a soft reset; the soft reset bit itself never stores
      enable_group_two      <= (`RST_ENABLE_GROUP_TWO & ~(8'h01 << `BIT_BOOST_PRECHARGE)) |
                               (enable_group_two & (8'h01 << `BIT_BOOST_PRECHARGE));
      supervisor_control    <= `RST_SUPERVISOR_CONTROL;
      sleep_duration_high   <= `RST_SLEEP_DURATION_HIGH;
      sleep_duration_low    <= `RST_SLEEP_DURATION_LOW;
      pin_and_mux_config    <= `RST_PIN_AND_MUX_CONFIG;
      gas_amp_and_load_test <= `RST_GAS_AMP_AND_LOAD_TEST;
    end else begin
      // A software write wins over the clear at expiry
      if (wr_en2) begin
        enable_group_two <= i_reg_wdata & `MSK_ENABLE_GROUP_TWO;
      end else if (sleep_expire) begin
        enable_group_two[`BIT_SLEEP_ENABLE] <= 1'b0;
      end

      if (wr_ctl) begin
        supervisor_control <= i_reg_wdata & `MSK_SUPERVISOR_CONTROL;
      end

      if (wr_hi) begin
        sleep_duration_high <= i_reg_wdata;
      end

      if (wr_lo) begin
        sleep_duration_low <= i_reg_wdata;
      end

      if (wr_pin) begin
        pin_and_mux_config <= i_reg_wdata & `MSK_PIN_AND_MUX_CONFIG;
      end

      if (wr_gas) begin
        gas_amp_and_load_test <= i_reg_wdata & `MSK_GAS_AMP_AND_LOAD_TEST;
      end
    end
  end

  // Read port; unmapped offsets return zero
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `OFS_ENABLE_GROUP_TWO:      o_reg_rdata <= enable_group_two;
        `OFS_SUPERVISOR_CONTROL:    o_reg_rdata <= supervisor_control;
        `OFS_SLEEP_DURATION_HIGH:   o_reg_rdata <= sleep_duration_high;
        `OFS_SLEEP_DURATION_LOW:    o_reg_rdata <= sleep_duration_low;
        `OFS_PIN_AND_MUX_CONFIG:    o_reg_rdata <= pin_and_mux_config;
        `OFS_GAS_AMP_AND_LOAD_TEST: o_reg_rdata <= gas_amp_and_load_test;
        default:                    o_reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep timer

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN  = 2'h2;

  reg [1:0]       state;
  reg [1:0]       next_state;
  // Latched duration, elapsed milliseconds, cycles within one
  reg [DUR_W-1:0] ms_target;
  reg [DUR_W-1:0] ms_count;
  reg [31:0]      tick_count;

  // Start only on a 0 to 1 write of sleep enable
  wire en_rising = wr_en2 && i_reg_wdata[`BIT_SLEEP_ENABLE] && !sleep_en;
  // One tick per millisecond of core clock cycles
  wire tick      = (tick_count == TICK_CYCLES - 1);
  wire dur_write = wr_hi || wr_lo;
  wire [DUR_W-1:0] dur_after = {wr_hi ? i_reg_wdata : sleep_duration_high,
                                wr_lo ? i_reg_wdata : sleep_duration_low};

  assign sleep_expire = (state == ST_RUN) && tick && (ms_count == ms_target - 1'b1);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (en_rising) begin
          next_state = (duration != {DUR_W{1'b0}}) ? ST_RUN : ST_WAIT;
        end
      end
      // Enabled with a zero duration: park until it turns nonzero
      ST_WAIT: begin
        if (soft_rst || (wr_en2 && !i_reg_wdata[`BIT_SLEEP_ENABLE])) begin
          next_state = ST_IDLE;
        end else if (dur_write && dur_after != {DUR_W{1'b0}}) begin
          next_state = ST_RUN;
        end
      end
      // Stop on a zero write or soft reset, else run to expiry
      ST_RUN: begin
        if (soft_rst || (wr_en2 && !i_reg_wdata[`BIT_SLEEP_ENABLE]) || sleep_expire) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state        <= ST_IDLE;
      ms_target    <= {DUR_W{1'b0}};
      ms_count     <= {DUR_W{1'b0}};
      tick_count   <= 32'h0;
      o_sleep_done <= 1'b0;
    end else begin
      state        <= next_state;
      o_sleep_done <= sleep_expire;
      // Duration is latched at start, so later rewrites wait for the next start
      if (state != ST_RUN && next_state == ST_RUN) begin
        ms_target  <= (state == ST_WAIT) ? dur_after : duration;
        ms_count   <= {DUR_W{1'b0}};
        tick_count <= 32'h0;
      end else if (state == ST_RUN) begin
        if (tick) begin
          tick_count <= 32'h0;
          ms_count   <= ms_count + 1'b1;
        end else begin
          tick_count <= tick_count + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor, boost and faults

  wire mon_on  = !supervisor_control[`BIT_BROWNOUT_MONITOR_OFF];
  // Supply low only counts while the monitor runs
  wire low_q   = s_low && mon_on;
  // Precharge runs boost only while power good is low; the bit is not cleared
  wire pre_run = enable_group_two[`BIT_BOOST_PRECHARGE] && !s_pg;
  wire low_run = supervisor_control[`BIT_LOW_SUPPLY_BOOST] && low_q;
  wire reg_flt = s_regerr && !supervisor_control[`BIT_REG_ERROR_FAULT_OFF];
  wire ot_flt  = s_ot && supervisor_control[`BIT_OVERTEMP_FAULT_CTRL];

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing

  wire [2:0] pin_mode = pin_and_mux_config[`POS_PIN_MODE_HI:`POS_PIN_MODE_LO];
  wire [1:0] mux_sel  = pin_and_mux_config[`POS_MUX_SELECT_HI:`POS_MUX_SELECT_LO];
  wire mux_byp  = pin_and_mux_config[`BIT_MUX_BYPASS];
  wire led_sel  = enable_group_two[`BIT_LED_CHANNEL_SELECT];
  wire int_dir  = enable_group_two[`BIT_INT_DIRECTION];
  // Pin input codes merge with the LED enable pins and the load test enable bit
  wire mp_a     = (pin_mode == `PIN_MODE_OR_LED_A) && s_mp;
  wire mp_b     = (pin_mode == `PIN_MODE_OR_LED_B) && s_mp;
  wire mp_t     = (pin_mode == `PIN_MODE_OR_LOAD_TEST) && s_mp;
  wire led_blk  = enable_group_two[`BIT_LED_PIN_GATE] && s_led_pin;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_led_a_on            <= 1'b0;
      o_led_b_on            <= 1'b0;
      o_horn_on             <= 1'b0;

      o_boost_run           <= 1'b0;
      o_host_regulator_on   <= 1'b1;
      o_brownout_mon_on     <= 1'b1;
      o_supply_low_flag     <= 1'b0;

      o_fault_mode          <= 1'b0;
      o_overtemp_error_flag <= 1'b0;
      o_load_test_on        <= 1'b0;
      o_mux_select          <= `MUX_OFF;
      o_mux_buffer_on       <= 1'b0;
      o_mux_bypass_on       <= 1'b0;

      o_sleep_active        <= 1'b0;
      o_soft_reset          <= 1'b0;
      o_gas_amp_and_load_test <= `RST_GAS_AMP_AND_LOAD_TEST;

      o_int_unit            <= 1'b0;
      o_int_unit_oe_n       <= 1'b1;
      o_int_mcu             <= 1'b0;
      o_int_mcu_oe_n        <= 1'b1;
      o_mp_pin              <= 1'b0;
      o_mp_pin_oe_n         <= 1'b1;
    end else begin
      o_led_a_on            <= led_blk && !led_sel && (s_led_a || mp_a);
      o_led_b_on            <= led_blk && led_sel && (s_led_b || mp_b);
      o_horn_on             <= enable_group_two[`BIT_SOUNDER_GATE] && s_sounder;
      o_boost_run           <= i_boost_enable || pre_run || low_run;
      o_host_regulator_on   <= !supervisor_control[`BIT_HOST_REGULATOR_OFF];
      o_brownout_mon_on     <= mon_on;
      o_supply_low_flag     <= low_q;

      // Set wins over a clear arriving in the same cycle
      o_fault_mode          <= reg_flt || ot_flt || (o_fault_mode && !i_fault_clr);
      o_overtemp_error_flag <= ot_flt || (o_overtemp_error_flag && !i_overtemp_flag_clr);
      o_load_test_on        <= i_load_test_enable || mp_t;
      o_mux_select          <= mux_sel;
      o_mux_buffer_on       <= !mux_byp && (mux_sel != `MUX_OFF);
      o_mux_bypass_on       <= mux_byp && (mux_sel != `MUX_OFF);

      o_sleep_active        <= (next_state == ST_RUN);
      o_soft_reset          <= soft_rst;
      o_gas_amp_and_load_test <= gas_amp_and_load_test;

      // Direction 0 forwards unit side to MCU side, 1 the reverse
      o_int_mcu             <= s_unit;
      o_int_mcu_oe_n        <= int_dir;
      o_int_unit            <= s_mcu;
      o_int_unit_oe_n       <= !int_dir;
      o_mp_pin              <= i_status_error_any;
      o_mp_pin_oe_n         <= (pin_mode != `PIN_MODE_ERROR_OUT);
    end
  end

endmodule

// ===== src/alarm_afe_consts.vh
// Register offsets, field positions, reset values and timing for the alarm front-end control bank
`ifndef ALARM_AFE_CONSTS_VH
`define ALARM_AFE_CONSTS_VH

`define OFS_ENABLE_GROUP_TWO      8'h07
`define OFS_SUPERVISOR_CONTROL    8'h08
`define OFS_SLEEP_DURATION_HIGH   8'h09
`define OFS_SLEEP_DURATION_LOW    8'h0a
`define OFS_PIN_AND_MUX_CONFIG    8'h0b
`define OFS_GAS_AMP_AND_LOAD_TEST 8'h0c

`define RST_ENABLE_GROUP_TWO      8'h00
`define RST_SUPERVISOR_CONTROL    8'h00
`define RST_SLEEP_DURATION_HIGH   8'h00
`define RST_SLEEP_DURATION_LOW    8'h00
`define RST_PIN_AND_MUX_CONFIG    8'h00
`define RST_GAS_AMP_AND_LOAD_TEST 8'h00

// Writable bits of each register; reserved bits read zero
`define MSK_ENABLE_GROUP_TWO      8'hcf
`define MSK_SUPERVISOR_CONTROL    8'h3d
`define MSK_PIN_AND_MUX_CONFIG    8'hb7
`define MSK_GAS_AMP_AND_LOAD_TEST 8'hf7

// enable_group_two fields
`define BIT_LED_CHANNEL_SELECT    7
`define BIT_BOOST_PRECHARGE       6
`define BIT_INT_DIRECTION         3
`define BIT_LED_PIN_GATE          2
`define BIT_SOUNDER_GATE          1
`define BIT_SLEEP_ENABLE          0

// supervisor_control fields
`define BIT_HOST_REGULATOR_OFF    5
`define BIT_BROWNOUT_MONITOR_OFF  4
`define BIT_REG_ERROR_FAULT_OFF   3
`define BIT_OVERTEMP_FAULT_CTRL   2
`define BIT_SOFT_RESET            1
`define BIT_LOW_SUPPLY_BOOST      0

// pin_and_mux_config fields
`define BIT_MUX_BYPASS            7
`define POS_MUX_SELECT_HI         5
`define POS_MUX_SELECT_LO         4
`define POS_PIN_MODE_HI           2
`define POS_PIN_MODE_LO           0

// Analog mux select codes
`define MUX_OFF                   2'h0
`define MUX_GAS_AMP_OUTPUT        2'h1
`define MUX_PHOTO_GAIN_OUTPUT     2'h2
`define MUX_PHOTODIODE_OUTPUT     2'h3

// Multi-purpose pin codes
`define PIN_MODE_HIGH_Z           3'h0
`define PIN_MODE_ERROR_OUT        3'h2
`define PIN_MODE_OR_LED_A         3'h4
`define PIN_MODE_OR_LED_B         3'h5
`define PIN_MODE_OR_LOAD_TEST     3'h7

// Sleep timer tick: one millisecond at an 8 ns core clock
`define CORE_CLK_PERIOD_NS        8
`define SLEEP_TICK_NS             1000000
`define SLEEP_TICK_CYCLES         (`SLEEP_TICK_NS / `CORE_CLK_PERIOD_NS)

`endif

// ===== dv/host_bus_model.sv
// Host-side model that issues one-cycle write and read strobes to the control bank
`timescale 1ns/10ps
module host_bus_model (
  input  wire       i_core_clk,  // Core clock
  input  wire [7:0] i_reg_rdata, // Read data from the bank
  output reg  [7:0] o_reg_addr,  // Register offset
  output reg  [7:0] o_reg_wdata, // Write data
  output reg        o_reg_wr,    // Write strobe
  output reg        o_reg_rd     // Read strobe
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data is scrambled once the strobe drops so a stale value is never read back
  task reg_write(input [7:0] addr, input [7:0] data);
    @(posedge i_core_clk);
    #1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    o_reg_wr = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_wdata = ~data;
  endtask

  task reg_read(input [7:0] addr, output [7:0] data);
    @(posedge i_core_clk);
    #1;
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~addr;
    data = i_reg_rdata;
  endtask
endmodule

// ===== dv/alarm_afe_control_regs_checker.sv
// Assertions on register write effects and pulse timing of the control bank
`timescale 1ns/10ps
module alarm_afe_control_regs_checker (
  input wire       i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_boost_enable, i_status_error_any,
  input wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire       o_int_unit_oe_n, o_int_mcu_oe_n, o_mp_pin, o_mp_pin_oe_n, o_boost_run,
  input wire       o_host_regulator_on, o_mux_buffer_on, o_mux_bypass_on, o_sleep_done, o_soft_reset,
  input wire [1:0] o_mux_select
);
  reg [7:0] wd1;
  reg [7:0] wd2;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  always @(posedge i_core_clk) begin
    wd1 <= i_reg_wdata;
    wd2 <= wd1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  int_direction_a: assert property (
    i_reg_wr && i_reg_addr == 8'h07 ##1 !i_reg_wr |-> ##1 o_int_mcu_oe_n == wd2[3] && o_int_unit_oe_n == !wd2[3])
    else $error("interconnect direction does not follow register");
  host_regulator_a: assert property (
    i_reg_wr && i_reg_addr == 8'h08 && !i_reg_wdata[1] ##1 !i_reg_wr |-> ##1 o_host_regulator_on == !wd2[5])
    else $error("host regulator enable wrong");
  mux_select_a: assert property (
    i_reg_wr && i_reg_addr == 8'h0b ##1 !i_reg_wr |-> ##1 o_mux_select == wd2[5:4])
    else $error("mux select does not follow register");
  mux_exclusive_a: assert property (!(o_mux_buffer_on && o_mux_bypass_on) &&
    (o_mux_buffer_on || o_mux_bypass_on) == (o_mux_select != 2'h0)) else $error("mux buffer or bypass wrong");
  error_pin_a: assert property (!o_mp_pin_oe_n && $past(o_mp_pin_oe_n) == 1'b0
    |-> o_mp_pin == $past(i_status_error_any)) else $error("error pin level wrong");
  soft_reset_pulse_a: assert property (
    i_reg_wr && i_reg_addr == 8'h08 && i_reg_wdata[1] |=> o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset pulse wrong");
  sleep_done_pulse_a: assert property ($rose(o_sleep_done) |=> !o_sleep_done)
    else $error("sleep done longer than one cycle");
  boost_follow_a: assert property (i_boost_enable |=> o_boost_run)
    else $error("boost not running with enable");
  read_after_write_a: assert property (i_reg_wr && i_reg_addr == 8'h0b ##1 !i_reg_wr
    ##1 i_reg_rd && i_reg_addr == 8'h0b |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 8'hb7))
    else $error("pin and mux readback wrong");
endmodule

bind alarm_afe_control_regs alarm_afe_control_regs_checker alarm_afe_control_regs_checker_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_boost_enable(i_boost_enable), .i_status_error_any(i_status_error_any), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_int_unit_oe_n(o_int_unit_oe_n),
  .o_int_mcu_oe_n(o_int_mcu_oe_n), .o_mp_pin(o_mp_pin), .o_mp_pin_oe_n(o_mp_pin_oe_n), .o_boost_run(o_boost_run),
  .o_host_regulator_on(o_host_regulator_on), .o_mux_buffer_on(o_mux_buffer_on), .o_mux_bypass_on(o_mux_bypass_on),
  .o_sleep_done(o_sleep_done), .o_soft_reset(o_soft_reset), .o_mux_select(o_mux_select));

// ===== dv/alarm_afe_control_regs_test.sv
// Testbench of the alarm front-end control bank
`timescale 1ns/10ps
module alarm_afe_control_regs_test;
  reg core_clk = 1'b0, rst = 1'b1, boost_en = 1'b0, err_any = 1'b0, ot_clr = 1'b0, fault_clr = 1'b0;
  reg led_a_in = 1'b0, led_pin = 1'b0, sounder = 1'b0, pg = 1'b0, slow = 1'b0, reg_err = 1'b0, ot = 1'b0;
  reg ext_unit = 1'b0, ext_mcu = 1'b0, ext_mp = 1'b0;
  wire [7:0] addr, wdata, rdata, gas;
  wire [1:0] msel;
  wire wr, rd, unit_o, unit_oe_n, mcu_o, mcu_oe_n, mp_o, mp_oe_n, led_a, led_b, horn, boost, hreg, bmon;
  wire slflag, fault, otf, ltest, mbuf, mbyp, sact, sdone, srst;
  wire unit_w = unit_oe_n ? ext_unit : unit_o;
  wire mcu_w = mcu_oe_n ? ext_mcu : mcu_o;
  wire mp_w = mp_oe_n ? ext_mp : mp_o;
  integer bad_count = 0, cmp_count = 0, i, n;
  reg [7:0] v;

  always #4 core_clk = ~core_clk;

  host_bus_model host_bus_model_i (.i_core_clk(core_clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));

  alarm_afe_control_regs #(.TICK_CYCLES(4)) alarm_afe_control_regs_i (
    .i_core_clk(core_clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_boost_enable(boost_en), .i_load_test_enable(1'b0), .i_status_error_any(err_any),
    .i_overtemp_flag_clr(ot_clr), .i_fault_clr(fault_clr), .i_led_a_enable_input(led_a_in),
    .i_led_b_enable_input(1'b0), .i_led_enable_pin(led_pin), .i_sounder_enable_pin(sounder),
    .i_boost_power_good(pg), .i_supply_low(slow), .i_regulator_error(reg_err), .i_overtemp(ot),
    .i_int_unit(unit_w), .o_int_unit(unit_o), .o_int_unit_oe_n(unit_oe_n), .i_int_mcu(mcu_w), .o_int_mcu(mcu_o),
    .o_int_mcu_oe_n(mcu_oe_n), .i_mp_pin(mp_w), .o_mp_pin(mp_o), .o_mp_pin_oe_n(mp_oe_n), .o_led_a_on(led_a),
    .o_led_b_on(led_b), .o_horn_on(horn), .o_boost_run(boost), .o_host_regulator_on(hreg),
    .o_brownout_mon_on(bmon), .o_supply_low_flag(slflag), .o_fault_mode(fault), .o_overtemp_error_flag(otf),
    .o_load_test_on(ltest), .o_mux_select(msel), .o_mux_buffer_on(mbuf), .o_mux_bypass_on(mbyp),
    .o_sleep_active(sact), .o_sleep_done(sdone), .o_soft_reset(srst), .o_gas_amp_and_load_test(gas));

  ////////////////////////////////////////////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task wait_cyc(input integer c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  // Write, then let registered outputs settle
  task wrs(input [7:0] a, input [7:0] d);
    host_bus_model_i.reg_write(a, d);
    wait_cyc(2);
  endtask

  task rchk(input [7:0] a, input [7:0] exp);
    host_bus_model_i.reg_read(a, v);
    check(v, exp);
  endtask

  task wait_done;
    n = 0;
    while (sdone !== 1'b1 && n < 1100) begin
      @(posedge core_clk);
      #1;
      n = n + 1;
    end
  endtask

  initial begin
    #100000;
    bad_count = bad_count + 1;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wait_cyc(10);
    rst = 1'b0;
    for (i = 7; i <= 13; i = i + 1) rchk(i[7:0], 8'h00);
    check({hreg, bmon}, 2'b11);
    wrs(8'h09, 8'hff);
    rchk(8'h09, 8'hff);
    wrs(8'h0a, 8'hff);
    rchk(8'h0a, 8'hff);
    wrs(8'h0c, 8'hff);
    rchk(8'h0c, 8'hf7);
    host_bus_model_i.reg_write(8'h0b, 8'hff);
    rchk(8'h0b, 8'hb7);
    wrs(8'h08, 8'hfd);
    rchk(8'h08, 8'h3d);
    wrs(8'h07, 8'hce);
    rchk(8'h07, 8'hce);
    check({hreg, bmon, msel, mbyp, mbuf, mp_oe_n, boost}, 8'h3b);
    check(gas, 8'hf7);
    pg = 1'b1;
    wait_cyc(5);
    check(boost, 1'b0);
    wrs(8'h08, 8'h02);
    rchk(8'h07, 8'h40);
    for (i = 8; i <= 12; i = i + 1) rchk(i[7:0], 8'h00);
    check({hreg, bmon}, 2'b11);
    wrs(8'h07, 8'h00);
    pg = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      wrs(8'h0b, {2'b00, i[1:0], 4'h0});
      check({msel, mbuf}, {i[1:0], i != 0});
    end
    ext_unit = 1'b1;
    wait_cyc(5);
    check({mcu_oe_n, unit_oe_n, mcu_o}, 3'b011);
    ext_unit = 1'b0;
    wait_cyc(5);
    check(mcu_o, 1'b0);
    wrs(8'h07, 8'h08);
    ext_mcu = 1'b1;
    wait_cyc(5);
    check({unit_oe_n, mcu_oe_n, unit_o}, 3'b011);
    wrs(8'h0b, 8'h02);
    err_any = 1'b1;
    wait_cyc(2);
    check({mp_oe_n, mp_o}, 2'b01);
    err_any = 1'b0;
    wait_cyc(2);
    check({mp_oe_n, mp_o}, 2'b00);
    wrs(8'h0b, 8'h00);
    check(mp_oe_n, 1'b1);
    led_pin = 1'b1;
    ext_mp = 1'b1;
    wrs(8'h07, 8'h04);
    wrs(8'h0b, 8'h04);
    wait_cyc(5);
    check({led_a, led_b}, 2'b10);
    wrs(8'h07, 8'h84);
    wrs(8'h0b, 8'h05);
    check({led_a, led_b}, 2'b01);
    wrs(8'h07, 8'h80);
    check({led_a, led_b}, 2'b00);
    wrs(8'h0b, 8'h07);
    check(ltest, 1'b1);
    ext_mp = 1'b0;
    sounder = 1'b1;
    wrs(8'h07, 8'h02);
    wait_cyc(5);
    check({horn, ltest}, 2'b10);
    wrs(8'h07, 8'h00);
    check(horn, 1'b0);
    wrs(8'h08, 8'h04);
    ot = 1'b1;
    wait_cyc(5);
    check({fault, otf}, 2'b11);
    ot = 1'b0;
    ot_clr = 1'b1;
    fault_clr = 1'b1;
    wait_cyc(5);
    check({fault, otf}, 2'b00);
    wrs(8'h08, 8'h00);
    ot = 1'b1;
    wait_cyc(5);
    check({fault, otf}, 2'b00);
    ot = 1'b0;
    fault_clr = 1'b0;
    reg_err = 1'b1;
    wait_cyc(5);
    check(fault, 1'b1);
    fault_clr = 1'b1;
    wrs(8'h08, 8'h08);
    fault_clr = 1'b0;
    wait_cyc(5);
    check(fault, 1'b0);
    reg_err = 1'b0;
    boost_en = 1'b1;
    wait_cyc(2);
    check(boost, 1'b1);
    boost_en = 1'b0;
    wrs(8'h08, 8'h01);
    slow = 1'b1;
    wait_cyc(5);
    check({boost, slflag}, 2'b11);
    wrs(8'h08, 8'h00);
    check({boost, slflag}, 2'b01);
    slow = 1'b0;
    wrs(8'h09, 8'h01);
    wrs(8'h0a, 8'h02);
    host_bus_model_i.reg_write(8'h07, 8'h01);
    wait_done;
    check(n, 16'd1032);
    rchk(8'h07, 8'h00);
    wrs(8'h09, 8'h00);
    wrs(8'h0a, 8'h03);
    host_bus_model_i.reg_write(8'h07, 8'h01);
    host_bus_model_i.reg_write(8'h0a, 8'h01);
    wait_done;
    check(n, 16'd10);
    host_bus_model_i.reg_write(8'h07, 8'h01);
    wrs(8'h07, 8'h00);
    wait_done;
    check({sact, n[14:0]}, {1'b0, 15'd1100});
    wrs(8'h0a, 8'h00);
    host_bus_model_i.reg_write(8'h07, 8'h01);
    wait_cyc(10);
    check(sact, 1'b0);
    host_bus_model_i.reg_write(8'h0a, 8'h01);
    wait_done;
    check(n, 16'd4);
    end_sim;
  end
endmodule
